// [core/mq_defs.svh]
/*
 * Constants for the queue port: address fields, geometry, config layout.
 * Assumes inclusion by bare name.
 */
`ifndef MQ_DEFS_SVH
`define MQ_DEFS_SVH

// queue and sector geometry
`define QUEUE_COUNT 16
`define QSEL_W 4
`define FLAG_BUS_W 8
`define SEC_LO 1'h0

// write address fields
`define WA_W 7
`define WA_DEV_HI 6
`define WA_DEV_LO 4
`define WA_Q_HI 3
`define WA_SEC_BIT 0

// read address fields
`define RA_W 8
`define RA_DEV_HI 7
`define RA_DEV_LO 5
`define RA_NULL_BIT 4
`define RA_Q_HI 3
`define RA_SEC_BIT 0

// configuration word: id, almost-empty level, almost-full level
`define CFG_BITS 7
`define CFG_CNT_W 3
`define CFG_LAST 3'h6
`define CFG_ID_HI 6
`define CFG_ID_LO 4
`define CFG_AE_HI 3
`define CFG_AE_LO 2
`define CFG_AF_HI 1
`define CFG_AF_LO 0
`define DEV_ID_W 3
`define LVL_W 2

// master reset pulse length
`define MRS_CYCLES 4'h4
`define MRS_CNT_W 4

`endif

// [core/mq_pkg.sv]
/*
 * Types used by the controller end of the queue port.
 * Assumes nothing of its surroundings.
 */
package mq_pkg;
    // controller sequencing
    typedef enum logic [1:0] {
        HS_MRESET,
        HS_IDLE,
        HS_SHIFT,
        HS_RUN
    } host_state_t;
endpackage

// [core/mq_port_if.sv]
/*
 * Pin carrier between queue device and host.
 * Assumes one shared core clock; all pins one-way.
 */
`timescale 1ns/1ps
`include "mq_defs.svh"
interface mq_port_if #(parameter int WIDTH = 18);
    // reset and straps
    logic master_reset_n;
    logic flag_mode_select;
    logic serial_prog_select;
    // serial configuration chain
    logic serial_in;
    logic serial_chain_in_n;
    logic serial_out;
    logic serial_chain_out_n;
    // write port
    logic [`WA_W-1:0] write_queue_addr;
    logic write_addr_load;
    logic full_sector_strobe;
    logic write_en_n;
    logic [WIDTH-1:0] write_data;
    logic [`FLAG_BUS_W-1:0] almost_full_bus;
    logic almost_full_n;
    logic full_flag_n;
    logic full_poll_sync;
    // read port
    logic [`RA_W-1:0] read_queue_addr;
    logic read_addr_load;
    logic empty_sector_strobe;
    logic read_en_n;
    logic [WIDTH-1:0] read_data;
    logic output_valid_n;
    logic [`FLAG_BUS_W-1:0] almost_empty_bus;
    logic almost_empty_n;

    modport dev (
        input master_reset_n, flag_mode_select, serial_prog_select,
        input serial_in, serial_chain_in_n,
        output serial_out, serial_chain_out_n,
        input write_queue_addr, write_addr_load, full_sector_strobe, write_en_n, write_data,
        output almost_full_bus, almost_full_n, full_flag_n, full_poll_sync,
        input read_queue_addr, read_addr_load, empty_sector_strobe, read_en_n,
        output read_data, output_valid_n, almost_empty_bus, almost_empty_n
    );
    modport host (
        output master_reset_n, flag_mode_select, serial_prog_select,
        output serial_in, serial_chain_in_n,
        input serial_out, serial_chain_out_n,
        output write_queue_addr, write_addr_load, full_sector_strobe, write_en_n, write_data,
        input almost_full_bus, almost_full_n, full_flag_n, full_poll_sync,
        output read_queue_addr, read_addr_load, empty_sector_strobe, read_en_n,
        input read_data, output_valid_n, almost_empty_bus, almost_empty_n
    );
endinterface

// [core/mq_device.sv]
/*
 * Queue device end: sixteen small queues with write/read queue selection,
 * first-word-fall-through output, sector flag buses and serial configuration.
 * Assumes the host shares core_clk (write, read and serial clock are one).
 */
// Behaviour
// - first edge after select: old queue word
// - second edge: new queue word, no enable
// - empty strobe latches sector from bit 0
// - sector strobe edge still outputs old data
// - read with enable low, or forced on the two edges after a select; select always
// - empty bus cycles/selects without read enable
// - serial bit shifts in while chain enable low
// - chain enable out follows in once programmed
// - programmed and enabled: serial in to out
// - host chains serial data and enables
// - host feeds one serial clock to all
// - write queue latched only on address load
// - host never loads and strobes together
// - host selects queues only after programming
// - write address: queue low, device top bits
// - writes hit old queue two edges
// - write with enable low; select always
// - full bus cycles/selects without write enable
// - full strobe latches sector from bit 0
// - full-side flags on write clock
// - read queue latched only on address load
// - read address: queue, null bit, device
// - flag mode sampled at master reset
`timescale 1ns/1ps
`include "mq_defs.svh"
module mq_device #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4,
    parameter logic [`DEV_ID_W-1:0] DEF_ID = 3'h0,
    parameter logic [`LVL_W-1:0] DEF_AE = 2'h1,
    parameter logic [`LVL_W-1:0] DEF_AF = 2'h1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pins toward the host
    mq_port_if.dev link
);
    localparam int NQ = `QUEUE_COUNT;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    // picks one sector of eight flags out of sixteen
    function automatic logic [`FLAG_BUS_W-1:0] sector_pick(input logic [NQ-1:0] f, input logic sec);
        sector_pick = sec ? f[NQ-1:`FLAG_BUS_W] : f[`FLAG_BUS_W-1:0];
    endfunction

    logic mrst;
    logic flag_mode_q, serial_mode_q;
    logic [`CFG_BITS-1:0] cfg_q;
    logic [`CFG_CNT_W-1:0] bit_cnt_q;
    logic done_q;
    logic [`DEV_ID_W-1:0] my_id;
    logic [`LVL_W-1:0] ae_lvl, af_lvl;
    logic [WIDTH-1:0] mem_q [NQ*DEPTH];
    logic [PW-1:0] wptr_q [NQ];
    logic [PW-1:0] rptr_q [NQ];
    logic [CW-1:0] cnt_q [NQ];
    logic [NQ-1:0] push, pop, ae_n, af_n, full_n;
    logic [`QSEL_W-1:0] wr_sel_q, wr_act_q, rd_sel_q, rd_act_q;
    logic wr_mine_sel_q, wr_mine_q, rd_mine_sel_q, rd_mine_q;
    logic ld1_q, ld2_q;
    logic [WIDTH-1:0] rd_data_q;
    logic ov_n_q;
    logic af_sec_q, af_ok_q, ae_sec_q, ae_ok_q;
    logic [`FLAG_BUS_W-1:0] af_bus_q, ae_bus_q;
    logic af_n_q, ff_n_q, ae_n_q, sync_q;
    logic wr_id_hit, rd_id_hit, rd_take, rd_head_ok;

    assign mrst = rst || !link.master_reset_n;
    assign my_id = cfg_q[`CFG_ID_HI:`CFG_ID_LO];
    assign ae_lvl = cfg_q[`CFG_AE_HI:`CFG_AE_LO];
    assign af_lvl = cfg_q[`CFG_AF_HI:`CFG_AF_LO];

    // straps caught while master reset is low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_mode_q <= 1'b0;
            serial_mode_q <= 1'b0;
        end else if (!link.master_reset_n) begin
            flag_mode_q <= link.flag_mode_select;
            serial_mode_q <= link.serial_prog_select;
        end
    end

    // serial shift while chain enable is low
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            cfg_q <= {DEF_ID, DEF_AE, DEF_AF};
            bit_cnt_q <= '0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            if (!serial_mode_q) begin
                done_q <= 1'b1; // default programming finishes at once
            end else if (!link.serial_chain_in_n) begin
                cfg_q <= {cfg_q[`CFG_BITS-2:0], link.serial_in};
                bit_cnt_q <= bit_cnt_q + 1'b1;
                done_q <= (bit_cnt_q == `CFG_LAST);
            end
        end
    end

    // chain enable passes through once programmed
    assign link.serial_chain_out_n = done_q ? link.serial_chain_in_n : 1'b1;
    // serial data passes straight to the next device
    assign link.serial_out = (done_q && !link.serial_chain_in_n) ? link.serial_in : 1'b0;

    // device field must match the loaded id
    assign wr_id_hit = link.write_queue_addr[`WA_DEV_HI:`WA_DEV_LO] == my_id;
    // device field match; null bit selects no queue
    assign rd_id_hit = link.read_queue_addr[`RA_DEV_HI:`RA_DEV_LO] == my_id;

    // select latched on load, used two edges later
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            wr_sel_q <= '0;
            wr_mine_sel_q <= 1'b0;
            wr_act_q <= '0;
            wr_mine_q <= 1'b0;
        end else begin
            if (link.write_addr_load) begin
                wr_sel_q <= link.write_queue_addr[`WA_Q_HI:0];
                wr_mine_sel_q <= wr_id_hit && done_q;
            end
            wr_act_q <= wr_sel_q;
            wr_mine_q <= wr_mine_sel_q;
        end
    end

    // read select regardless of read enable
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            rd_sel_q <= '0;
            rd_mine_sel_q <= 1'b0;
            rd_act_q <= '0;
            rd_mine_q <= 1'b0;
            ld1_q <= 1'b0;
            ld2_q <= 1'b0;
        end else begin
            if (link.read_addr_load) begin
                rd_sel_q <= link.read_queue_addr[`RA_Q_HI:0];
                rd_mine_sel_q <= rd_id_hit && done_q && !link.read_queue_addr[`RA_NULL_BIT];
            end
            rd_act_q <= rd_sel_q;
            rd_mine_q <= rd_mine_sel_q;
            ld1_q <= link.read_addr_load;
            ld2_q <= ld1_q;
        end
    end

    // forced loads on both edges after a select
    assign rd_take = !link.read_en_n || ov_n_q || ld1_q || ld2_q;
    assign rd_head_ok = rd_mine_q && (cnt_q[rd_act_q] != '0);

    // per-queue pointers, occupancy and flags
    for (genvar g = 0; g < NQ; g++) begin : g_queue
        // write only with enable low into the active queue
        assign push[g] = wr_mine_q && !link.write_en_n && (wr_act_q == g) && full_n[g];
        assign pop[g] = rd_take && rd_head_ok && (rd_act_q == g);
        assign full_n[g] = cnt_q[g] != CW'(DEPTH);
        assign ae_n[g] = cnt_q[g] > CW'(ae_lvl);
        assign af_n[g] = cnt_q[g] < CW'(DEPTH) - CW'(af_lvl);
        always_ff @(posedge core_clk) begin
            if (mrst) begin
                wptr_q[g] <= '0;
                rptr_q[g] <= '0;
                cnt_q[g] <= '0;
            end else begin
                if (push[g]) wptr_q[g] <= wptr_q[g] + 1'b1;
                if (pop[g]) rptr_q[g] <= rptr_q[g] + 1'b1;
                cnt_q[g] <= cnt_q[g] + CW'(push[g]) - CW'(pop[g]);
            end
        end
    end

    // storage, indexed by queue then slot
    always_ff @(posedge core_clk) begin
        if (|push) mem_q[{wr_act_q, wptr_q[wr_act_q]}] <= link.write_data;
    end

    // output path runs on sector-strobe edges too
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            rd_data_q <= '0;
            ov_n_q <= 1'b1;
        end else if (rd_take) begin
            if (rd_head_ok) begin
                rd_data_q <= mem_q[{rd_act_q, rptr_q[rd_act_q]}];
                ov_n_q <= 1'b0;
            end else begin
                ov_n_q <= 1'b1; // read to empty: word no longer valid
            end
        end
    end

    // full-side sector: strobe or polling, no enable
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            af_sec_q <= `SEC_LO;
            af_ok_q <= 1'b0;
        end else if (flag_mode_q) begin
            af_sec_q <= ~af_sec_q;
            af_ok_q <= 1'b1;
        end else if (link.full_sector_strobe) begin
            af_sec_q <= link.write_queue_addr[`WA_SEC_BIT];
            af_ok_q <= wr_id_hit;
        end
    end

    // empty-side sector: strobe or polling, no enable
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            ae_sec_q <= `SEC_LO;
            ae_ok_q <= 1'b0;
        end else if (flag_mode_q) begin
            ae_sec_q <= ~ae_sec_q;
            ae_ok_q <= 1'b1;
        end else if (link.empty_sector_strobe) begin
            ae_sec_q <= link.read_queue_addr[`RA_SEC_BIT];
            ae_ok_q <= rd_id_hit;
        end
    end

    // full-side status registered on the write clock
    always_ff @(posedge core_clk) begin
        if (mrst) begin
            af_bus_q <= '1;
            af_n_q <= 1'b1;
            ff_n_q <= 1'b1;
            sync_q <= 1'b0;
        end else begin
            af_bus_q <= af_ok_q ? sector_pick(af_n, af_sec_q) : '1;
            af_n_q <= !wr_mine_q || af_n[wr_act_q];
            ff_n_q <= !wr_mine_q || full_n[wr_act_q];
            sync_q <= flag_mode_q && (af_sec_q == `SEC_LO);
        end
    end

    always_ff @(posedge core_clk) begin
        if (mrst) begin
            ae_bus_q <= '1;
            ae_n_q <= 1'b1;
        end else begin
            ae_bus_q <= ae_ok_q ? sector_pick(ae_n, ae_sec_q) : '1;
            ae_n_q <= !rd_mine_q || ae_n[rd_act_q];
        end
    end

    // outputs, all from flops
    assign link.read_data = rd_data_q;
    assign link.output_valid_n = ov_n_q;
    assign link.almost_full_bus = af_bus_q;
    assign link.almost_full_n = af_n_q;
    assign link.full_flag_n = ff_n_q;
    assign link.full_poll_sync = sync_q;
    assign link.almost_empty_bus = ae_bus_q;
    assign link.almost_empty_n = ae_n_q;
endmodule

// [core/mq_host.sv]
/*
 * Controller end: master reset, serial configuration, queue and sector
 * selection, writes and reads for user logic.
 * Assumes the device shares core_clk, also used as serial clock.
 */
`timescale 1ns/1ps
`include "mq_defs.svh"
module mq_host #(
    parameter int WIDTH = 18
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // straps and configuration
    input wire logic flag_mode_in,
    input wire logic serial_prog_in,
    input wire logic cfg_start,
    input wire logic [`CFG_BITS-1:0] cfg_word,
    output logic cfg_done,
    // write side requests
    input wire logic wq_sel_req,
    input wire logic [`WA_W-1:0] wq_sel_addr,
    input wire logic af_sec_req,
    input wire logic wr_req,
    input wire logic [WIDTH-1:0] wr_data,
    // read side requests
    input wire logic rq_sel_req,
    input wire logic [`RA_W-1:0] rq_sel_addr,
    input wire logic ae_sec_req,
    input wire logic rd_req,
    // pins toward the device
    mq_port_if.host link
);
    mq_pkg::host_state_t state_q;
    logic [`MRS_CNT_W-1:0] mrs_cnt_q;
    logic [`CFG_BITS-1:0] shift_q;
    logic [`CFG_CNT_W-1:0] bit_q;
    logic done_q;
    logic wr_ld, rd_ld;

    // selections only once the chain reports done
    assign wr_ld = done_q && wq_sel_req;
    assign rd_ld = done_q && rq_sel_req;

    // reset, then optional serial load of the chain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= mq_pkg::HS_MRESET;
            mrs_cnt_q <= '0;
            shift_q <= '0;
            bit_q <= '0;
            link.master_reset_n <= 1'b0;
            link.serial_chain_in_n <= 1'b1;
        end else begin
            unique case (state_q)
                mq_pkg::HS_MRESET: begin
                    mrs_cnt_q <= mrs_cnt_q + 1'b1;
                    if (mrs_cnt_q == `MRS_CYCLES) begin
                        link.master_reset_n <= 1'b1;
                        state_q <= serial_prog_in ? mq_pkg::HS_IDLE : mq_pkg::HS_RUN;
                        link.serial_chain_in_n <= serial_prog_in; // default load needs no shifting; enable low lets done pass
                    end
                end
                mq_pkg::HS_IDLE: begin
                    if (cfg_start) begin
                        shift_q <= cfg_word;
                        bit_q <= '0;
                        link.serial_chain_in_n <= 1'b0;
                        state_q <= mq_pkg::HS_SHIFT;
                    end
                end
                mq_pkg::HS_SHIFT: begin
                    // drive the head enable, data msb first
                    shift_q <= {shift_q[`CFG_BITS-2:0], 1'b0};
                    bit_q <= bit_q + 1'b1;
                    if (bit_q == `CFG_LAST) state_q <= mq_pkg::HS_RUN;
                end
                mq_pkg::HS_RUN: begin
                    link.serial_chain_in_n <= 1'b0; // held low so the chain stays done
                end
            endcase
        end
    end

    // serial data timed by the one shared clock
    assign link.serial_in = shift_q[`CFG_BITS-1];
    assign link.flag_mode_select = flag_mode_in;
    assign link.serial_prog_select = serial_prog_in;

    // watch the last enable out of the chain
    always_ff @(posedge core_clk) begin
        if (rst) done_q <= 1'b0;
        else done_q <= link.master_reset_n && !link.serial_chain_out_n;
    end
    assign cfg_done = done_q;

    // port requests registered right after each edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.write_queue_addr <= '0;
            link.write_addr_load <= 1'b0;
            link.full_sector_strobe <= 1'b0;
            link.write_en_n <= 1'b1;
            link.write_data <= '0;
            link.read_queue_addr <= '0;
            link.read_addr_load <= 1'b0;
            link.empty_sector_strobe <= 1'b0;
            link.read_en_n <= 1'b1;
        end else begin
            link.write_queue_addr <= wq_sel_addr;
            link.write_addr_load <= wr_ld;
            // a load wins; the strobe is dropped that cycle
            link.full_sector_strobe <= af_sec_req && !wr_ld;
            link.write_en_n <= !wr_req;
            link.write_data <= wr_data;
            link.read_queue_addr <= rq_sel_addr;
            link.read_addr_load <= rd_ld;
            link.empty_sector_strobe <= ae_sec_req && !rd_ld;
            link.read_en_n <= !rd_req;
        end
    end
endmodule

// [tb/mq_port_assertions.sv]
/*
 * Checks on the pins between queue device and host.
 * Assumes one clock and device identity DEV_ID.
 */
`timescale 1ns/1ps
`include "mq_defs.svh"
module mq_port_assertions #(
    parameter int WIDTH = 18,
    parameter logic [`DEV_ID_W-1:0] DEV_ID = 3'h0
) (
    // clock and reset
    input logic core_clk,
    input logic rst,
    // straps and serial chain
    input logic master_reset_n,
    input logic flag_mode_select,
    input logic serial_prog_select,
    input logic serial_in,
    input logic serial_chain_in_n,
    input logic serial_out,
    input logic serial_chain_out_n,
    // write port
    input logic [`WA_W-1:0] write_queue_addr,
    input logic write_addr_load,
    input logic full_sector_strobe,
    input logic [`FLAG_BUS_W-1:0] almost_full_bus,
    input logic almost_full_n,
    input logic full_flag_n,
    input logic full_poll_sync,
    // read port
    input logic read_addr_load,
    input logic empty_sector_strobe,
    input logic read_en_n,
    input logic [WIDTH-1:0] read_data,
    input logic output_valid_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // serial chain: shifting, pass-through, enable follow
    a_chain_follows: assert property (!serial_chain_out_n |-> !serial_chain_in_n)
        else $error("chain out low, in high");
    a_serial_pass: assert property (!serial_chain_out_n |-> serial_out == serial_in)
        else $error("serial not passed");
    a_shift_seven: assert property ($fell(serial_chain_out_n) && serial_prog_select |-> $past(serial_chain_in_n, 7) == 1'b0)
        else $error("done before seven shifts");
    // host ordering on both ports
    a_wr_load_strobe: assert property (!(write_addr_load && full_sector_strobe))
        else $error("load and strobe on write");
    a_rd_load_strobe: assert property (!(read_addr_load && empty_sector_strobe))
        else $error("load and strobe on read");
    a_load_after_prog: assert property (write_addr_load |-> !serial_chain_out_n)
        else $error("load before programming");
    // flag buses: polled sync cadence, direct mode quiet, foreign device blank
    a_sync_alternates: assert property (full_poll_sync |=> !full_poll_sync ##1 (full_poll_sync || !master_reset_n))
        else $error("sync not alternating");
    a_sync_direct: assert property (!flag_mode_select && master_reset_n |-> !full_poll_sync)
        else $error("sync pulse in direct mode");
    a_foreign_blank: assert property (full_sector_strobe && !flag_mode_select
        && write_queue_addr[`WA_DEV_HI:`WA_DEV_LO] != DEV_ID ##1 (!full_sector_strobe) [*2]
        |=> almost_full_bus == 8'hFF)
        else $error("full bus not blank");
    // output word held without a read or a forced load from a select
    a_read_holds: assert property (!output_valid_n && read_en_n && !$past(read_addr_load)
        && !$past(read_addr_load, 2) |=> $stable(read_data))
        else $error("word changed unread");
    a_full_almost: assert property (!full_flag_n |-> !almost_full_n)
        else $error("full without almost full");

    // main scenarios reached
    c_chain_done: cover property ($fell(serial_chain_out_n));
    c_wr_select: cover property (write_addr_load);
    c_poll_sync: cover property (full_poll_sync);
    c_read_pop: cover property (!read_en_n && !output_valid_n);
endmodule

// [tb/multi_queue_port_select_tb_top.sv]
/*
 * Bench for queue device and host on the pin carrier.
 * Assumes one clock; a queue model predicts reads and flags.
 */
`timescale 1ns/1ps
`include "mq_defs.svh"
module multi_queue_port_select_tb_top;
    localparam int WIDTH = 18;
    localparam int DEPTH = 4;
    // clock, reset and host requests
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic flag_mode_in = 1'b0;
    logic serial_prog_in = 1'b1;
    logic cfg_start = 1'b0;
    logic cfg_done;
    logic wq_sel_req = 1'b0, af_sec_req = 1'b0, wr_req = 1'b0;
    logic rq_sel_req = 1'b0, ae_sec_req = 1'b0, rd_req = 1'b0;
    logic [`WA_W-1:0] wq_sel_addr = 7'h00;
    logic [`RA_W-1:0] rq_sel_addr = 8'h00;
    logic [WIDTH-1:0] wr_data = 18'h00000;
    // bench state: random source, queue model
    logic [15:0] rnd = 16'h0057;
    logic [WIDTH-1:0] mq [16][$];
    int wact = -1, wmid = -1, prev = -1, errors = 0, checked = 0;
    logic [`WA_W-1:0] waddr [8] = '{7'h02, 7'h0A, 7'h52, 7'h0A, 7'h0F, 7'h08, 7'h02, 7'h0B};

    // free-running core clock
    always #50 core_clk = ~core_clk;

    mq_port_if #(.WIDTH(WIDTH)) link ();
    mq_device #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_mq_device (.core_clk(core_clk), .rst(rst), .link(link));
    mq_host #(.WIDTH(WIDTH)) i_mq_host (.core_clk(core_clk), .rst(rst), .flag_mode_in(flag_mode_in),
        .serial_prog_in(serial_prog_in), .cfg_start(cfg_start), .cfg_word(7'h05), .cfg_done(cfg_done),
        .wq_sel_req(wq_sel_req), .wq_sel_addr(wq_sel_addr), .af_sec_req(af_sec_req), .wr_req(wr_req),
        .wr_data(wr_data), .rq_sel_req(rq_sel_req), .rq_sel_addr(rq_sel_addr), .ae_sec_req(ae_sec_req),
        .rd_req(rd_req), .link(link));
    mq_port_assertions #(.WIDTH(WIDTH), .DEV_ID(3'h0)) i_mq_port_assertions (.core_clk(core_clk), .rst(rst),
        .master_reset_n(link.master_reset_n), .flag_mode_select(link.flag_mode_select),
        .serial_prog_select(link.serial_prog_select), .serial_in(link.serial_in),
        .serial_chain_in_n(link.serial_chain_in_n), .serial_out(link.serial_out),
        .serial_chain_out_n(link.serial_chain_out_n), .write_queue_addr(link.write_queue_addr),
        .write_addr_load(link.write_addr_load), .full_sector_strobe(link.full_sector_strobe),
        .almost_full_bus(link.almost_full_bus), .almost_full_n(link.almost_full_n),
        .full_flag_n(link.full_flag_n), .full_poll_sync(link.full_poll_sync),
        .read_addr_load(link.read_addr_load), .empty_sector_strobe(link.empty_sector_strobe),
        .read_en_n(link.read_en_n), .read_data(link.read_data), .output_valid_n(link.output_valid_n));

    always @(posedge core_clk) begin
        if (rst || !link.master_reset_n) begin
            wact = -1;
            wmid = -1;
            foreach (mq[i]) mq[i].delete();
        end else begin
            if (!link.write_en_n && wact >= 0 && mq[wact].size() < DEPTH) mq[wact].push_back(link.write_data);
            wact = wmid;
            if (link.write_addr_load) wmid = link.write_queue_addr[6:4] == 3'h0 ? int'(link.write_queue_addr[3:0]) : -1;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // expected sector bus from model counts
    function automatic logic [7:0] bus_exp(input int s, input bit full);
        for (int i = 0; i < 8; i++) bus_exp[i] = full ? mq[s*8+i].size() < DEPTH - 1 : mq[s*8+i].size() > 1;
    endfunction

    task automatic chk_word(input logic [WIDTH-1:0] got, input logic [WIDTH-1:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bus(input logic [7:0] got, input logic [7:0] exp, input string what);
        chk_word(WIDTH'(got), WIDTH'(exp), what);
    endtask

    task automatic report_and_stop;
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wait_done;
        for (int i = 0; i < 40 && cfg_done !== 1'b1; i++) @(posedge core_clk);
        chk_bus(8'(cfg_done), 8'h01, "config done");
        chk_bus(8'(link.serial_chain_out_n), 8'h00, "chain enable out");
    endtask

    // both sector strobes, don't-care bits set
    task automatic flags(input int s, input logic [`WA_W-1:0] wa);
        wq_sel_addr <= wa;
        rq_sel_addr <= s ? 8'h1D : 8'h1C;
        af_sec_req <= 1'b1;
        ae_sec_req <= 1'b1;
        @(posedge core_clk);
        af_sec_req <= 1'b0;
        ae_sec_req <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk_bus(link.almost_full_bus, wa[6:4] != 3'h0 ? 8'hFF : bus_exp(s, 1'b1), "full bus");
        chk_bus(link.almost_empty_bus, bus_exp(s, 1'b0), "empty bus");
        @(posedge core_clk);
    endtask

    // select with enable off, drain to one word
    task automatic sel_read(input logic [`RA_W-1:0] ra);
        int q;
        q = ra[4] ? -1 : int'(ra[3:0]);
        rq_sel_addr <= ra;
        rq_sel_req <= 1'b1;
        @(posedge core_clk);
        rq_sel_req <= 1'b0;
        for (int n = 0; n < 10; n++) begin
            @(negedge core_clk);
            if (link.read_addr_load === 1'b1) break;
        end
        repeat (2) @(posedge core_clk);
        #1;
        if (prev >= 0 && mq[prev].size() > 0) chk_word(link.read_data, mq[prev].pop_front(), "old word");
        else chk_bus(8'(link.output_valid_n), 8'h01, "old empty");
        @(posedge core_clk);
        #1;
        if (q >= 0) chk_word(link.read_data, mq[q].pop_front(), "new head");
        chk_bus(8'(link.output_valid_n), 8'(q < 0), "valid after select");
        prev = q;
        while (q >= 0 && mq[q].size() > 1) begin
            @(posedge core_clk);
            rd_req <= 1'b1;
            @(posedge core_clk);
            rd_req <= 1'b0;
            repeat (3) @(posedge core_clk);
            #1;
            chk_word(link.read_data, mq[q].pop_front(), "popped word");
        end
        @(posedge core_clk);
    endtask

    // main sequence
    initial begin
        int n;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        cfg_start <= 1'b1;
        @(posedge core_clk);
        cfg_start <= 1'b0;
        wait_done();
        // random writes across queue changes, overfill
        for (int c = 0; c < 48; c++) begin
            rnd = lfsr(rnd);
            wr_req <= rnd[0] | rnd[1];
            wr_data <= {rnd[1:0], rnd};
            wq_sel_req <= c % 6 == 0;
            wq_sel_addr <= waddr[c/6];
            @(posedge core_clk);
        end
        wr_req <= 1'b0;
        wq_sel_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_bus(8'(link.full_flag_n), 8'(mq[11].size() < DEPTH), "full flag");
        chk_bus(8'(link.almost_full_n), 8'(mq[11].size() < DEPTH - 1), "almost full");
        @(posedge core_clk);
        flags(0, 7'h51);
        flags(0, 7'h0E);
        flags(1, 7'h0F);
        for (int q = 0; q < 16; q++) if (mq[q].size() > 0) sel_read({4'h0, 4'(q)});
        sel_read(8'h13);
        // second run: polled flag buses, default programming
        rst <= 1'b1;
        flag_mode_in <= 1'b1;
        serial_prog_in <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_done();
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            n += link.full_poll_sync;
            chk_bus(link.almost_empty_bus, 8'h00, "polled empty bus");
            chk_bus(link.almost_full_bus, 8'hFF, "polled full bus");
        end
        chk_bus(8'(n), 8'h04, "sync count");
        report_and_stop();
    end

    // watchdog far beyond the expected run
    initial begin
        #(4000 * 100);
        errors++;
        report_and_stop();
    end
endmodule
